/* design/adc_scan_defs.svh */
`ifndef ADC_SCAN_DEFS_SVH
`define ADC_SCAN_DEFS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_CONTROL        8'h04
`define IDX_PRESCALE       8'h09
`define IDX_INTERVAL       8'h0C
`define IDX_FIRST_CHAN     8'h10
`define IDX_LAST_CHAN      8'h11
`define IDX_START_CONVERT  8'h24

// ****************************************************************
// control word fields
// ****************************************************************
`define CTRL_FORMAT_BIT    0
`define CTRL_MODE_LSB      8
`define CTRL_MODE_MSB      10
`define CTRL_TIMER_EN_BIT  11
`define CTRL_RW_MASK       16'h3F3F
`define PRESCALE_LSB       8
`define START_CONVERT_BIT  0

// ****************************************************************
// scan mode codes
// ****************************************************************
`define MODE_DISABLED      3'h0
`define MODE_UNIFORM_CONT  3'h1
`define MODE_UNIFORM_ONCE  3'h2
`define MODE_BURST_CONT    3'h3
`define MODE_BURST_ONCE    3'h4
`define MODE_EXT_TRIGGER   3'h5

// ****************************************************************
// reset values and timing
// ****************************************************************
`define RESET_WORD8        8'h00
`define RESET_WORD16       16'h0000
`define CLK_MHZ            50
`define REF_MHZ            8
`define REF_ACC_MOD        6'(`CLK_MHZ)
`define REF_ACC_STEP       6'(`REF_MHZ)

`endif

/* design/adc_scan_pkg.sv */
`default_nettype none

package adc_scan_pkg;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h1,
    ST_WAIT_TRIG = 4'h2,
    ST_CONVERT   = 4'h4,
    ST_WAIT_DONE = 4'h8
  } seq_state_t;

endpackage

`default_nettype wire

/* design/adc_scan_timer_sequencer.sv */
// Contract
// - format bit 0 clear gives two's complement, set gives offset binary results.
// - offset binary is two's complement with the sign bit inverted.
// - first counter divides the 8 MHz reference by prescaler, bits 15:8.
// - second counter divides prescaler output by the 16-bit interval value.
// - triggers spaced prescaler times interval over 8 MHz.
// - prescaler and interval take 8/16/32-bit access, clear on reset.
// - scan starts at first channel and covers through last channel inclusive.
// - last channel register defines end of scan, bits 15:8 when combined.
// - equal first and last channel converts that single channel per trigger.
// - channel bounds take byte or combined access, unused bits read zero.
// - both channel bound registers clear on reset.
// - channel pointer reloads from first channel whenever conversions halt.
// - control bit 11 enables the periodic timer, cleared at reset.
// - control bits 10:8 select the scan mode, 101 external trigger, timer triggers too when bit 11 set.
// - writing one to start-convert bit 0 starts acquisition.
`include "adc_scan_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_scan_timer_sequencer (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // converter side
  input  wire logic        conv_done_in,
  input  wire logic [15:0] conv_data_in,
  input  wire logic        ext_trigger_in,
  output logic             conv_start_out,
  output logic      [7:0]  channel_out,
  output logic             scan_active_out,
  output logic             trigger_out,
  // result buffer side
  output logic             result_valid_out,
  output logic      [15:0] result_data_out,
  output logic      [7:0]  result_channel_out
);

  // ****************************************************************
  // bus address phase capture
  // ****************************************************************
  logic       ap_write;
  logic [7:0] ap_index;
  logic [3:0] ap_lanes;
  logic       next_ap_write;
  logic [7:0] next_ap_index;
  logic [3:0] next_ap_lanes;

  // register state
  logic [15:0] control;
  logic [7:0]  trigger_prescale_divisor;
  logic [15:0] trigger_interval_divisor;
  logic [7:0]  scan_first_channel;
  logic [7:0]  scan_last_channel;
  logic        start_pulse;
  logic [15:0] next_control;
  logic [7:0]  next_prescale;
  logic [15:0] next_interval;
  logic [7:0]  next_first;
  logic [7:0]  next_last;
  logic        next_start_pulse;

  // decoded control fields
  logic [2:0] scan_mode;
  logic       timer_en;
  logic       offset_fmt;

  assign scan_mode  = control[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign timer_en   = control[`CTRL_TIMER_EN_BIT];
  assign offset_fmt = control[`CTRL_FORMAT_BIT];

  // byte lanes from size and low address bits
  function automatic logic [3:0] lanes_of(input logic [2:0] size, input logic [1:0] low);
    logic [3:0] l;
    l = 4'hF;
    if (size == 3'h0) begin
      l = 4'h1 << low;
    end else if (size == 3'h1) begin
      l = low[1] ? 4'hC : 4'h3;
    end
    return l;
  endfunction

  // merge written byte lanes into a 32-bit view
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // address phase and register writes
  always_comb begin
    logic [31:0] m;
    m                = 32'h0000_0000;
    next_ap_write    = 1'b0;
    next_ap_index    = 8'h00;
    next_ap_lanes    = 4'h0;
    next_control     = control;
    next_prescale    = trigger_prescale_divisor;
    next_interval    = trigger_interval_divisor;
    next_first       = scan_first_channel;
    next_last        = scan_last_channel;
    next_start_pulse = 1'b0;
    if (hsel_in && htrans_in[1] && hready_in) begin
      next_ap_write = hwrite_in;
      next_ap_index = haddr_in[9:2];
      next_ap_lanes = lanes_of(hsize_in, haddr_in[1:0]);
    end
    if (ap_write) begin
      if (ap_index == `IDX_CONTROL) begin
        m            = merge({16'h0000, control}, hwdata_in, ap_lanes);
        next_control = m[15:0] & `CTRL_RW_MASK;
      end else if (ap_index == `IDX_PRESCALE) begin
        m             = merge({16'h0000, trigger_prescale_divisor, 8'h00}, hwdata_in, ap_lanes);
        next_prescale = m[15:8];
      end else if (ap_index == `IDX_INTERVAL) begin
        m             = merge({16'h0000, trigger_interval_divisor}, hwdata_in, ap_lanes);
        next_interval = m[15:0];
      end else if (ap_index == `IDX_FIRST_CHAN) begin
        m          = merge({16'h0000, scan_last_channel, scan_first_channel}, hwdata_in,
                           ap_lanes);
        next_first = m[7:0];
        next_last  = m[15:8];
      end else if (ap_index == `IDX_LAST_CHAN) begin
        m         = merge({24'h000000, scan_last_channel}, hwdata_in, ap_lanes);
        next_last = m[7:0];
      end else if (ap_index == `IDX_START_CONVERT) begin
        next_start_pulse = ap_lanes[0] && hwdata_in[`START_CONVERT_BIT];
      end
    end
  end

  // register group flops, all cleared at reset
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ap_write                 <= 1'b0;
      ap_index                 <= 8'h00;
      ap_lanes                 <= 4'h0;
      control                  <= `RESET_WORD16;
      trigger_prescale_divisor <= `RESET_WORD8;
      trigger_interval_divisor <= `RESET_WORD16;
      scan_first_channel       <= `RESET_WORD8;
      scan_last_channel        <= `RESET_WORD8;
      start_pulse              <= 1'b0;
    end else begin
      ap_write                 <= next_ap_write;
      ap_index                 <= next_ap_index;
      ap_lanes                 <= next_ap_lanes;
      control                  <= next_control;
      trigger_prescale_divisor <= next_prescale;
      trigger_interval_divisor <= next_interval;
      scan_first_channel       <= next_first;
      scan_last_channel        <= next_last;
      start_pulse              <= next_start_pulse;
    end
  end

  // ****************************************************************
  // read data and response
  // ****************************************************************
  always_comb begin
    hrdata_out = 32'h0000_0000;
    if (ap_index == `IDX_CONTROL) begin
      hrdata_out = {16'h0000, control};
    end else if (ap_index == `IDX_PRESCALE) begin
      hrdata_out = {16'h0000, trigger_prescale_divisor, 8'h00};
    end else if (ap_index == `IDX_INTERVAL) begin
      hrdata_out = {16'h0000, trigger_interval_divisor};
    end else if (ap_index == `IDX_FIRST_CHAN) begin
      hrdata_out = {16'h0000, scan_last_channel, scan_first_channel};
    end else if (ap_index == `IDX_LAST_CHAN) begin
      hrdata_out = {24'h000000, scan_last_channel};
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // ****************************************************************
  // cascaded trigger counters
  // ****************************************************************
  adc_scan_pkg::seq_state_t state;
  adc_scan_pkg::seq_state_t next_state;

  logic [5:0]  ref_acc;
  logic [7:0]  pre_cnt;
  logic [15:0] int_cnt;
  logic        timer_trig;
  logic [5:0]  next_ref_acc;
  logic [7:0]  next_pre_cnt;
  logic [15:0] next_int_cnt;
  logic        next_timer_trig;
  logic        ref_tick;
  logic        pre_tick;
  logic        timer_run;

  // run only while enabled and scanning
  assign timer_run = timer_en && (state != adc_scan_pkg::ST_IDLE);

  // 8 MHz enable from 50 MHz by fractional accumulation, then two dividers
  always_comb begin
    logic [6:0] sum;
    sum             = {1'b0, ref_acc} + {1'b0, `REF_ACC_STEP};
    next_ref_acc    = sum[5:0];
    ref_tick        = 1'b0;
    pre_tick        = 1'b0;
    next_pre_cnt    = pre_cnt;
    next_int_cnt    = int_cnt;
    next_timer_trig = 1'b0;
    if (sum >= {1'b0, `REF_ACC_MOD}) begin
      next_ref_acc = 6'(sum - {1'b0, `REF_ACC_MOD});
      ref_tick     = 1'b1;
    end
    if (!timer_run) begin
      next_ref_acc = 6'h00;
      next_pre_cnt = trigger_prescale_divisor;
      next_int_cnt = trigger_interval_divisor;
    end else begin
      if (ref_tick && trigger_prescale_divisor != 8'h00) begin
        if (pre_cnt <= 8'h01) begin
          next_pre_cnt = trigger_prescale_divisor;
          pre_tick     = 1'b1;
        end else begin
          next_pre_cnt = pre_cnt - 8'h01;
        end
      end
      if (pre_tick && trigger_interval_divisor != 16'h0000) begin
        if (int_cnt <= 16'h0001) begin
          next_int_cnt    = trigger_interval_divisor;
          next_timer_trig = 1'b1;
        end else begin
          next_int_cnt = int_cnt - 16'h0001;
        end
      end
    end
  end

  // counter flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ref_acc    <= 6'h00;
      pre_cnt    <= 8'h00;
      int_cnt    <= 16'h0000;
      timer_trig <= 1'b0;
    end else begin
      ref_acc    <= next_ref_acc;
      pre_cnt    <= next_pre_cnt;
      int_cnt    <= next_int_cnt;
      timer_trig <= next_timer_trig;
    end
  end

  // ****************************************************************
  // scan sequencer
  // ****************************************************************
  logic [7:0]  chan_ptr;
  logic        soft_pend;
  logic        res_valid;
  logic [15:0] res_data;
  logic [7:0]  res_chan;
  logic [7:0]  next_chan_ptr;
  logic        next_soft_pend;
  logic        next_res_valid;
  logic [15:0] next_res_data;
  logic [7:0]  next_res_chan;
  logic        trig_now;
  logic        burst;
  logic        once;
  logic        ext_mode;

  assign ext_mode = scan_mode == `MODE_EXT_TRIGGER;
  assign burst    = scan_mode == `MODE_BURST_CONT || scan_mode == `MODE_BURST_ONCE || ext_mode;
  assign once     = scan_mode == `MODE_UNIFORM_ONCE || scan_mode == `MODE_BURST_ONCE;
  // timer feeds triggers only when enabled
  assign trig_now = (timer_en && timer_trig) || (ext_mode && ext_trigger_in) || soft_pend;

  always_comb begin
    next_state     = state;
    next_chan_ptr  = chan_ptr;
    next_res_valid = 1'b0;
    next_res_data  = res_data;
    next_res_chan  = res_chan;
    // software trigger held when neither timer nor external trigger paces the scan; set wins
    next_soft_pend = (start_pulse && !timer_en && !ext_mode) ||
                     (soft_pend && !(state == adc_scan_pkg::ST_WAIT_TRIG));
    case (state)
      adc_scan_pkg::ST_IDLE: begin
        // pointer follows first channel while halted
        next_chan_ptr = scan_first_channel;
        if (start_pulse && scan_mode != `MODE_DISABLED) begin
          next_state = adc_scan_pkg::ST_WAIT_TRIG;
        end
      end
      adc_scan_pkg::ST_WAIT_TRIG: begin
        if (scan_mode == `MODE_DISABLED) begin
          next_state = adc_scan_pkg::ST_IDLE;
        end else if (trig_now) begin
          next_state = adc_scan_pkg::ST_CONVERT;
        end
      end
      adc_scan_pkg::ST_CONVERT: begin
        next_state = adc_scan_pkg::ST_WAIT_DONE;
      end
      adc_scan_pkg::ST_WAIT_DONE: begin
        if (conv_done_in) begin
          next_res_valid = 1'b1;
          next_res_chan  = chan_ptr;
          next_res_data  = offset_fmt ? {~conv_data_in[15], conv_data_in[14:0]} : conv_data_in;
          if (chan_ptr >= scan_last_channel) begin
            next_chan_ptr = scan_first_channel;
            if (once || scan_mode == `MODE_DISABLED) begin
              next_state = adc_scan_pkg::ST_IDLE;
            end else begin
              next_state = adc_scan_pkg::ST_WAIT_TRIG;
            end
          end else begin
            next_chan_ptr = chan_ptr + 8'h01;
            next_state    = burst ? adc_scan_pkg::ST_CONVERT : adc_scan_pkg::ST_WAIT_TRIG;
          end
        end
      end
      default: begin
        next_state = adc_scan_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state     <= adc_scan_pkg::ST_IDLE;
      chan_ptr  <= 8'h00;
      soft_pend <= 1'b0;
      res_valid <= 1'b0;
      res_data  <= 16'h0000;
      res_chan  <= 8'h00;
    end else begin
      state     <= next_state;
      chan_ptr  <= next_chan_ptr;
      soft_pend <= next_soft_pend;
      res_valid <= next_res_valid;
      res_data  <= next_res_data;
      res_chan  <= next_res_chan;
    end
  end

  // outputs
  assign conv_start_out     = state == adc_scan_pkg::ST_CONVERT;
  assign channel_out        = chan_ptr;
  assign scan_active_out    = state != adc_scan_pkg::ST_IDLE;
  assign trigger_out        = timer_trig;
  assign result_valid_out   = res_valid;
  assign result_data_out    = res_data;
  assign result_channel_out = res_chan;

endmodule

`default_nettype wire

/* verification/adc_scan_timer_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_scan_timer_sequencer_checker (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // bus answer
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // converter side
  input wire logic        conv_done_in,
  input wire logic [15:0] conv_data_in,
  input wire logic        conv_start_out,
  input wire logic [7:0]  channel_out,
  input wire logic        scan_active_out,
  input wire logic        trigger_out,
  // result side
  input wire logic        result_valid_out,
  input wire logic [15:0] result_data_out,
  input wire logic [7:0]  result_channel_out
);
  logic        done_q;
  logic [15:0] data_q;
  logic [7:0]  chan_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // delayed copies of converter handshake for result checks
  always_ff @(posedge clk_in) begin
    done_q <= conv_done_in;
    data_q <= conv_data_in;
    chan_q <= channel_out;
  end

  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus slave not ready or not okay");
  a_reset_clears: assert property ($past(reset_in) |-> !scan_active_out && channel_out == 8'h00
    && !result_valid_out && !trigger_out)
    else $error("state not cleared by reset");
  a_result_after_done: assert property (result_valid_out |-> done_q)
    else $error("result without converter done");
  a_result_low_bits: assert property (result_valid_out |-> result_data_out[14:0] == data_q[14:0])
    else $error("result magnitude bits differ from sample");
  a_result_chan_tag: assert property (result_valid_out |-> result_channel_out == chan_q)
    else $error("result channel not the converted channel");
  a_result_hold: assert property (!result_valid_out |-> $stable(result_data_out)
    && $stable(result_channel_out))
    else $error("result changed without valid");
  a_start_one_cycle: assert property (conv_start_out |=> !conv_start_out)
    else $error("conversion start longer than one cycle");
  a_trig_one_cycle: assert property (trigger_out |=> !trigger_out)
    else $error("trigger longer than one cycle");
  a_start_in_scan: assert property (conv_start_out |-> scan_active_out)
    else $error("conversion start while idle");
  a_chan_steady: assert property (conv_start_out |=> $stable(channel_out))
    else $error("channel moved during conversion");

  c_result: cover property (result_valid_out);
endmodule

bind adc_scan_timer_sequencer adc_scan_timer_sequencer_checker adc_scan_timer_sequencer_checker_inst (
  .clk_in(clk_in), .reset_in(reset_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .conv_start_out(conv_start_out),
  .channel_out(channel_out), .scan_active_out(scan_active_out), .trigger_out(trigger_out),
  .result_valid_out(result_valid_out), .result_data_out(result_data_out),
  .result_channel_out(result_channel_out)
);

`default_nettype wire

/* verification/adc_scan_timer_sequencer_tb_top.sv */
`include "adc_scan_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_scan_timer_sequencer_tb_top;
  // ****************************************************************
  // signals and tables
  // ****************************************************************
  typedef struct {logic [31:0] a; logic [2:0] sz; logic [31:0] wd; logic [31:0] ra;
    logic [31:0] exp;} row_t;
  localparam logic [31:0] A_CTL  = {22'h0, `IDX_CONTROL, 2'h0};
  localparam logic [31:0] A_PS   = {22'h0, `IDX_PRESCALE, 2'h0};
  localparam logic [31:0] A_IV   = {22'h0, `IDX_INTERVAL, 2'h0};
  localparam logic [31:0] A_CH   = {22'h0, `IDX_FIRST_CHAN, 2'h0};
  localparam logic [31:0] A_LAST = {22'h0, `IDX_LAST_CHAN, 2'h0};
  localparam logic [31:0] A_GO   = {22'h0, `IDX_START_CONVERT, 2'h0};
  localparam int          GAP    = 64 * 2 * `CLK_MHZ / `REF_MHZ;
  logic        clk_in = 1'b0, reset_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic        conv_done_in = 1'b0, ext_trigger_in = 1'b0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out;
  logic [1:0]  htrans_in = 2'h0;
  logic [2:0]  hsize_in = 3'h0;
  logic [15:0] conv_data_in = 16'h0, result_data_out;
  logic        hreadyout_out, hresp_out, conv_start_out, scan_active_out, trigger_out;
  logic        result_valid_out;
  logic [7:0]  channel_out, result_channel_out;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  int          trig_cyc [$];
  logic [15:0] codes [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
  logic [31:0] rst_addr [4] = '{A_PS, A_IV, A_CH, A_CTL};
  row_t        rows [11] = '{
    '{A_PS, 3'h2, 32'hFFFFFFFF, A_PS, 32'h0000FF00},
    '{A_PS + 1, 3'h0, 32'h00004000, A_PS, 32'h00004000},
    '{A_IV, 3'h2, 32'hFFFF1234, A_IV, 32'h00001234},
    '{A_IV, 3'h1, 32'h0000BEEF, A_IV, 32'h0000BEEF},
    '{A_CH, 3'h2, 32'hFFFF0502, A_CH, 32'h00000502},
    '{A_LAST, 3'h0, 32'h00000009, A_CH, 32'h00000902},
    '{A_CH, 3'h0, 32'h00000003, A_LAST, 32'h00000009},
    '{A_CH + 1, 3'h0, 32'h00000700, A_CH, 32'h00000703},
    '{A_CTL, 3'h2, 32'hFFFFF9FF, A_CTL, 32'h0000393F},
    '{32'h00000200, 3'h2, 32'hFFFFFFFF, 32'h00000200, 32'h0},
    '{A_GO, 3'h2, 32'h0000FFFE, A_GO, 32'h0}};

  adc_scan_timer_sequencer adc_scan_timer_sequencer_inst (
    .clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hready_in(hreadyout_out), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in), .ext_trigger_in(ext_trigger_in),
    .conv_start_out(conv_start_out), .channel_out(channel_out),
    .scan_active_out(scan_active_out), .trigger_out(trigger_out),
    .result_valid_out(result_valid_out), .result_data_out(result_data_out),
    .result_channel_out(result_channel_out));

  // clock
  always #10 clk_in = ~clk_in;

  // cycle count, trigger times and hang limit
  always @(posedge clk_in) begin
    cyc++;
    if (trigger_out === 1'b1) trig_cyc.push_back(cyc);
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // single ahb-lite transfer, read data taken at the data phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    hsel_in <= 1'b1; htrans_in <= 2'h2; haddr_in <= a; hwrite_in <= w; hsize_in <= sz;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0; hwdata_in <= wd;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask

  // converter answers one start and the result is compared
  task automatic convert(input logic [7:0] ch, input logic [15:0] s, input logic fmt);
    int k;
    k = 0;
    while (conv_start_out !== 1'b1 && k < 3000) begin
      @(posedge clk_in);
      k++;
    end
    chk("conv_start", {31'h0, conv_start_out}, 32'h1);
    chk("conv_chan", {24'h0, channel_out}, {24'h0, ch});
    conv_done_in <= 1'b1; conv_data_in <= s;
    @(posedge clk_in);
    conv_done_in <= 1'b0; conv_data_in <= ~s;
    @(posedge clk_in);
    chk("res_valid", {31'h0, result_valid_out}, 32'h1);
    chk("res_data", {16'h0, result_data_out}, {16'h0, fmt ? s ^ 16'h8000 : s});
    chk("res_chan", {24'h0, result_channel_out}, {24'h0, ch});
  endtask

  // halt, set bounds and mode, start, then serve the whole scan
  task automatic scan(input logic [7:0] f, input logic [7:0] l, input logic [31:0] ctl,
                      input logic ext);
    logic [31:0] d;
    int c;
    bus(1'b1, A_CTL, 3'h2, 32'h0, d);
    bus(1'b1, A_CH, 3'h1, {16'h0, l, f}, d);
    bus(1'b1, A_CTL, 3'h2, ctl, d);
    bus(1'b1, A_GO, 3'h0, 32'h1, d);
    if (ext) begin
      @(posedge clk_in);
      ext_trigger_in <= 1'b1;
      @(posedge clk_in);
      ext_trigger_in <= 1'b0;
    end
    for (c = f; c <= l; c++) convert(8'(c), codes[c % 4], ctl[0]);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [31:0] k;
    int g;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (rst_addr[i]) begin
      bus(1'b0, rst_addr[i], 3'h2, 32'h0, d);
      chk("reset_val", d, 32'h0);
    end
    $display("test reset values done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].sz, rows[i].wd, d);
      bus(1'b0, rows[i].ra, 3'h2, 32'h0, d);
      chk("reg_rw", d, rows[i].exp);
    end
    chk("no_start", {31'h0, scan_active_out}, 32'h0);
    $display("test register table done");
    scan(8'h02, 8'h05, 32'h00000400, 1'b0);
    repeat (4) @(posedge clk_in);
    chk("idle_after", {31'h0, scan_active_out}, 32'h0);
    chk("ptr_reload", {24'h0, channel_out}, 32'h2);
    $display("test burst single done");
    scan(8'h01, 8'h03, 32'h00000301, 1'b0);
    bus(1'b1, A_CTL, 3'h2, 32'h0, d);
    repeat (4) @(posedge clk_in);
    chk("halt_idle", {31'h0, scan_active_out}, 32'h0);
    chk("halt_ptr", {24'h0, channel_out}, 32'h1);
    $display("test burst continuous halt done");
    bus(1'b1, A_CH, 3'h1, 32'h00000401, d);
    bus(1'b1, A_CTL, 3'h2, 32'h00000100, d);
    bus(1'b1, A_GO, 3'h0, 32'h1, d);
    convert(8'h01, codes[1], 1'b0);
    chk("mid_ptr", {24'h0, channel_out}, 32'h2);
    bus(1'b1, A_CTL, 3'h2, 32'h0, d);
    repeat (4) @(posedge clk_in);
    chk("mid_halt_ptr", {24'h0, channel_out}, 32'h1);
    $display("test halt mid scan done");
    scan(8'h07, 8'h07, 32'h00000200, 1'b0);
    k = 32'h0;
    repeat (40) begin
      @(posedge clk_in);
      if (conv_start_out === 1'b1) k++;
    end
    chk("extra_start", k, 32'h0);
    $display("test single channel done");
    scan(8'h01, 8'h02, 32'h00000500, 1'b1);
    $display("test external trigger done");
    chk("no_timer", 32'(trig_cyc.size()), 32'h0);
    bus(1'b1, A_PS, 3'h2, 32'h00004000, d);
    bus(1'b1, A_IV, 3'h2, 32'h00000002, d);
    trig_cyc.delete();
    scan(8'h00, 8'h00, 32'h00000901, 1'b0);
    convert(8'h00, codes[0], 1'b1);
    convert(8'h00, codes[0], 1'b1);
    bus(1'b1, A_CTL, 3'h2, 32'h0, d);
    chk("trig_count", (trig_cyc.size() >= 3) ? 32'h1 : 32'h0, 32'h1);
    for (g = 1; g < 3 && g < trig_cyc.size(); g++) begin
      k = 32'(trig_cyc[g] - trig_cyc[g - 1]);
      chk("trig_gap", (k >= GAP - 1 && k <= GAP + 1) ? 32'h1 : 32'h0, 32'h1);
    end
    $display("test timer spacing done");
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (rst_addr[i]) begin
      bus(1'b0, rst_addr[i], 3'h2, 32'h0, d);
      chk("mid_reset_val", d, 32'h0);
    end
    $display("test mid-run reset done");
    summarize();
  end
endmodule

`default_nettype wire
